// ===== dv/opdvr_host.sv
`timescale 1ns/10ps
`include "opdvr_consts.vh"
// ****************************************
// control bus host model
// ****************************************
module opdvr_host (
  input  wire logic       clk_sys,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata_ff
);
  // strobes quiet from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `OPDVR_OFS_POP) begin
      v[0] = 1'b0;
      if (v[7:6] == 2'b11) begin
        v[7:4] = 4'hb;
      end
    end
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask

  // read data is registered, taken once the strobe edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = reg_rdata_ff;
  endtask
endmodule

// ===== dv/opdvr_top_props.sv
`timescale 1ns/10ps
// ****************************************
// port checks for the register bank
// ****************************************
module opdvr_chk #(
  parameter [15:0] TICK_CYC = 16'h0014
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [1:0]  vol_link,
  input wire logic [1:0]  soft_step_mode,
  input wire logic        sample_rate_tick,
  input wire logic        drv_pwr_req,
  input wire logic        drv_delaying,
  input wire logic        drv_powered,
  input wire logic        vcm_from_bandgap,
  input wire logic        dac_l_mute,
  input wire logic [6:0]  dac_l_atten,
  input wire logic [6:0]  dac_r_atten,
  input wire logic        dac_vol_busy,
  input wire logic [48:0] ana_vol_codes,
  input wire logic [69:0] ana_gain_tdb_ff,
  input wire logic [6:0]  ana_mute_ff
);
  // one clock domain, so one default clock and reset
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // register fields follow the written byte one edge later
  property p_mute_l;
    reg_wr && reg_addr == 8'h2b |=> dac_l_mute == $past(reg_wdata[7]);
  endproperty
  a_mute_l: assert property (p_mute_l) else $error("left mute bad");
  property p_vcm;
    reg_wr && reg_addr == 8'h2a |=> vcm_from_bandgap == $past(reg_wdata[1]);
  endproperty
  a_vcm: assert property (p_vcm) else $error("vcm source bad");

  // with stepping off the written code is applied two edges on
  property p_att_l;
    reg_wr && reg_addr == 8'h2b && vol_link == 2'b00
      && soft_step_mode == 2'b10 ##1 soft_step_mode == 2'b10
      && vol_link == 2'b00 && !reg_wr
      |=> dac_l_atten == $past(reg_wdata[6:0], 2);
  endproperty
  a_att_l: assert property (p_att_l) else $error("left atten bad");

  // per-sample stepping moves only on a sample tick, one code at most
  property p_ss_hold;
    soft_step_mode == 2'b00 && !sample_rate_tick
      |=> $stable(dac_l_atten) && $stable(dac_r_atten);
  endproperty
  a_ss_hold: assert property (p_ss_hold) else $error("step early");

  // a linked pair at rest shows one attenuation
  property p_link;
    (vol_link == 2'b01 || vol_link == 2'b10) && !dac_vol_busy
      |-> dac_l_atten == dac_r_atten;
  endproperty
  a_link: assert property (p_link) else $error("link bad");

  // analog decode is registered, the past code gives the answer
  property p_ana_mute;
    $past(nrst) |-> ana_mute_ff[6] == ($past(ana_vol_codes[48:42]) >= 7'd118);
  endproperty
  a_ana_mute: assert property (p_ana_mute) else $error("mute bad");
  property p_ana_lin;
    $past(nrst) && $past(ana_vol_codes[27:21]) <= 7'd36
      |-> ana_gain_tdb_ff[39:30] == 10'd5 * $past(ana_vol_codes[27:21]);
  endproperty
  a_ana_lin: assert property (p_ana_lin) else $error("gain bad");
  property p_ana_end;
    $past(nrst) && $past(ana_vol_codes[20:14]) == 7'd117
      |-> ana_gain_tdb_ff[29:20] == 10'd783 && !ana_mute_ff[2];
  endproperty
  a_ana_end: assert property (p_ana_end) else $error("117 bad");

  // dropping the request returns the driver to idle at once
  property p_pwr_off;
    !drv_pwr_req |=> !drv_powered && !drv_delaying;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("not idle");
  property p_pwr_on;
    $rose(drv_pwr_req) |=> drv_delaying;
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("no wait");

  // main scenarios reached
  c_powered: cover property ($rose(drv_powered));
  c_mute: cover property (ana_mute_ff[6]);
  c_link: cover property (vol_link == 2'b01 && dac_l_atten != 7'h00);
endmodule

bind opdvr_top opdvr_chk #(.TICK_CYC(TICK_CYC)) i_chk (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .vol_link(vol_link),
  .soft_step_mode(soft_step_mode), .sample_rate_tick(sample_rate_tick),
  .drv_pwr_req(drv_pwr_req), .drv_delaying(drv_delaying),
  .drv_powered(drv_powered), .vcm_from_bandgap(vcm_from_bandgap),
  .dac_l_mute(dac_l_mute), .dac_l_atten(dac_l_atten),
  .dac_r_atten(dac_r_atten), .dac_vol_busy(dac_vol_busy),
  .ana_vol_codes(ana_vol_codes), .ana_gain_tdb_ff(ana_gain_tdb_ff),
  .ana_mute_ff(ana_mute_ff)
);

// ===== dv/tb_opdvr_top.sv
`timescale 1ns/10ps
`include "opdvr_consts.vh"
// ****************************************
// register bank testbench
// ****************************************
module tb_opdvr_top;
  logic        clk_sys, nrst, sample_rate_tick, drv_pwr_req;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_ff, d;
  logic        reg_wr, reg_rd;
  logic [1:0]  vol_link, soft_step_mode;
  logic        drv_delaying, drv_ramp_step, drv_powered, vcm_from_bandgap;
  logic        dac_l_mute, dac_r_mute, dac_vol_busy;
  logic [6:0]  dac_l_atten, dac_r_atten, ana_mute_ff;
  logic [48:0] ana_vol_codes, cv;
  logic [69:0] ana_gain_tdb_ff;
  logic [6:0]  av [0:6] = '{7'd118, 7'd127, 7'd117, 7'd36, 7'd0, 7'd5, 7'd110};
  logic [9:0]  eg [0:6] = '{10'd783, 10'd783, 10'd783, 10'd180, 10'd0,
                            10'd25, 10'd583};
  int          bad_count, compares, i, p;
  int          dus [0:3] = '{0, 10, 100, 1000};
  int          sus [0:3] = '{0, 1000, 2000, 4000};

  // waits shortened to one cycle per microsecond
  opdvr_top #(.TICK_CYC(16'h0001)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .vol_link(vol_link), .soft_step_mode(soft_step_mode),
    .sample_rate_tick(sample_rate_tick), .drv_pwr_req(drv_pwr_req),
    .drv_delaying(drv_delaying), .drv_ramp_step(drv_ramp_step),
    .drv_powered(drv_powered), .vcm_from_bandgap(vcm_from_bandgap),
    .dac_l_mute(dac_l_mute), .dac_r_mute(dac_r_mute),
    .dac_l_atten(dac_l_atten), .dac_r_atten(dac_r_atten),
    .dac_vol_busy(dac_vol_busy), .ana_vol_codes(ana_vol_codes),
    .ana_gain_tdb_ff(ana_gain_tdb_ff), .ana_mute_ff(ana_mute_ff)
  );
  opdvr_host i_host (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff)
  );

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
      bad_count++;
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      sample_rate_tick <= 1'b1;
      @(posedge clk_sys);
      sample_rate_tick <= 1'b0;
    end
    @(negedge clk_sys);
  endtask

  // counts wait and ramp cycles; the bound covers the longest case
  task automatic pwr(input logic [3:0] dc, input logic [1:0] sc,
                     input int td, input int ts);
    int nd, np, nr, k;
    nd = 0;
    np = 0;
    nr = 0;
    i_host.wr(`OPDVR_OFS_POP, {dc, sc, 2'b00});
    @(posedge clk_sys);
    drv_pwr_req <= 1'b1;
    for (k = 0; k < 40000 && drv_powered !== 1'b1; k++) begin
      @(negedge clk_sys);
      nd += (drv_delaying === 1'b1);
      np += (drv_ramp_step === 1'b1);
      nr += (drv_delaying !== 1'b1 && drv_powered !== 1'b1);
    end
    if (drv_powered !== 1'b1) begin
      bad_count++;
      close_out();
    end
    chk("wait", nd >= td && nd <= td + 3, 1);
    chk("ramp", nr >= 8 * ts && nr <= 8 * ts + 12, 1);
    chk("steps", np, 8);
    @(posedge clk_sys);
    drv_pwr_req <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("off", drv_powered, 0);
  endtask

  // main sequence
  initial begin
    bad_count = 0;
    compares = 0;
    nrst = 1'b0;
    vol_link = 2'b00;
    soft_step_mode = 2'b10;
    sample_rate_tick = 1'b0;
    drv_pwr_req = 1'b0;
    ana_vol_codes = 49'h0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    i_host.rd(`OPDVR_OFS_LVOL, d);
    chk("lvol", d, 8'h80);
    i_host.rd(`OPDVR_OFS_POP, d);
    chk("pop", d, 8'h00);
    i_host.rd(`OPDVR_OFS_RVOL, d);
    chk("rvol", d, 8'h80);
    chk("rmute", dac_r_mute, 1);
    i_host.rd(8'h2d, d);
    chk("gap", d, 8'h00);
    i_host.wr(`OPDVR_OFS_POP, 8'h3e);
    @(negedge clk_sys);
    chk("vcm", vcm_from_bandgap, 1);
    i_host.rd(`OPDVR_OFS_POP, d);
    chk("pop", d, 8'h3e);
    i_host.wr(`OPDVR_OFS_POP, 8'h00);
    @(negedge clk_sys);
    chk("vcm", vcm_from_bandgap, 0);
    i_host.wr(`OPDVR_OFS_LVOL, 8'h7f);
    i_host.wr(`OPDVR_OFS_RVOL, 8'h05);
    repeat (2) @(negedge clk_sys);
    chk("lmute", dac_l_mute, 0);
    chk("latt", dac_l_atten, 7'h7f);
    chk("rmute", dac_r_mute, 0);
    chk("ratt", dac_r_atten, 7'h05);
    @(posedge clk_sys);
    soft_step_mode <= 2'b00;
    i_host.wr(`OPDVR_OFS_LVOL, 8'h7c);
    tick(1);
    chk("step1", dac_l_atten, 7'h7e);
    chk("busy", dac_vol_busy, 1);
    repeat (3) @(negedge clk_sys);
    chk("hold", dac_l_atten, 7'h7e);
    tick(2);
    chk("step3", dac_l_atten, 7'h7c);
    chk("busy", dac_vol_busy, 0);
    @(posedge clk_sys);
    soft_step_mode <= 2'b01;
    i_host.wr(`OPDVR_OFS_LVOL, 8'h7e);
    tick(2);
    chk("half", dac_l_atten, 7'h7d);
    tick(2);
    chk("step2x", dac_l_atten, 7'h7e);
    // every link code, left holds 7e and right 05
    @(posedge clk_sys);
    soft_step_mode <= 2'b10;
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      vol_link <= i[1:0];
      repeat (3) @(negedge clk_sys);
      chk("llink", dac_l_atten, (i == 1) ? 7'h05 : 7'h7e);
      chk("rlink", dac_r_atten, (i == 2) ? 7'h7e : 7'h05);
    end
    // each copy sees two codes of the table
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 7; i++) begin
        cv[7*i+:7] = av[(i + p) % 7];
      end
      @(posedge clk_sys);
      ana_vol_codes <= cv;
      repeat (2) @(negedge clk_sys);
      for (i = 0; i < 7; i++) begin
        chk("gain", ana_gain_tdb_ff[10*i+:10], eg[(i + p) % 7]);
        chk("amute", ana_mute_ff[i], (i + p) % 7 < 2);
      end
    end
    for (i = 0; i < 7; i++) begin
      pwr((i < 4) ? i[3:0] : 4'h0, (i < 4) ? 2'b00 : 2'(i - 3),
          dus[(i < 4) ? i : 0], sus[(i < 4) ? 0 : i - 3]);
    end
    close_out();
  end
endmodule

// ===== src/opdvr_consts.vh
`ifndef OPDVR_CONSTS_VH
`define OPDVR_CONSTS_VH

// ***************************************
// register map
// ***************************************
`define OPDVR_OFS_POP         8'h2a
`define OPDVR_OFS_LVOL        8'h2b
`define OPDVR_OFS_RVOL        8'h2c
`define OPDVR_RST_POP         8'h00
`define OPDVR_RST_VOL         8'h80

// ***************************************
// field positions
// ***************************************
`define OPDVR_POP_DLY_HI      7
`define OPDVR_POP_DLY_LO      4
`define OPDVR_POP_STP_HI      3
`define OPDVR_POP_STP_LO      2
`define OPDVR_POP_VCM_BIT     1
`define OPDVR_VOL_MUTE_BIT    7
`define OPDVR_VOL_ATT_HI      6

// ***************************************
// timing
// ***************************************
// cycles of the 20 MHz system clock in one microsecond
`define OPDVR_TICK_CYC        16'd20
`define OPDVR_DLY0_US         22'd0
`define OPDVR_DLY1_US         22'd10
`define OPDVR_DLY2_US         22'd100
`define OPDVR_DLY3_US         22'd1000
`define OPDVR_DLY4_US         22'd10000
`define OPDVR_DLY5_US         22'd50000
`define OPDVR_DLY6_US         22'd100000
`define OPDVR_DLY7_US         22'd200000
`define OPDVR_DLY8_US         22'd400000
`define OPDVR_DLY9_US         22'd800000
`define OPDVR_DLYA_US         22'd4000000
`define OPDVR_STP0_US         22'd0
`define OPDVR_STP1_US         22'd1000
`define OPDVR_STP2_US         22'd2000
`define OPDVR_STP3_US         22'd4000
`define OPDVR_RAMP_STEPS      4'd8

// ***************************************
// link and soft-step codes, first muted analog volume code
// ***************************************
`define OPDVR_LINK_L_FOLLOW   2'b01
`define OPDVR_LINK_R_FOLLOW   2'b10
`define OPDVR_SS_EVERY        2'b00
`define OPDVR_SS_EVERY2       2'b01
`define OPDVR_MUTE_FIRST      7'd118

`endif

// ===== src/opdvr_pwr_seq.v
`timescale 1ns/10ps
`include "opdvr_consts.vh"

// driver power-on wait followed by a stepped ramp
module opdvr_pwr_seq #(
  parameter [15:0] TICK_CYC = `OPDVR_TICK_CYC
) (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire       pwr_req,
  input  wire [3:0] dly_code,
  input  wire [1:0] stp_code,
  output wire       delaying,
  output reg        ramp_step_ff,
  output wire       powered
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DLY  = 2'd1;
  localparam [1:0] ST_RAMP = 2'd2;
  localparam [1:0] ST_ON   = 2'd3;

  reg [1:0]  state_ff;
  reg [15:0] pre_ff;
  reg [21:0] us_ff;
  reg [3:0]  stp_ff;
  wire       tick;
  wire       dly_done;
  wire       stp_done;

  // upper reserved codes fall back to the longest wait
  function [21:0] dly_us;
    input [3:0] c;
    begin
      case (c)
        4'd0: dly_us = `OPDVR_DLY0_US;
        4'd1: dly_us = `OPDVR_DLY1_US;
        4'd2: dly_us = `OPDVR_DLY2_US;
        4'd3: dly_us = `OPDVR_DLY3_US;
        4'd4: dly_us = `OPDVR_DLY4_US;
        4'd5: dly_us = `OPDVR_DLY5_US;
        4'd6: dly_us = `OPDVR_DLY6_US;
        4'd7: dly_us = `OPDVR_DLY7_US;
        4'd8: dly_us = `OPDVR_DLY8_US;
        4'd9: dly_us = `OPDVR_DLY9_US;
        default: dly_us = `OPDVR_DLYA_US;
      endcase
    end
  endfunction

  function [21:0] stp_us;
    input [1:0] c;
    begin
      case (c)
        2'd0: stp_us = `OPDVR_STP0_US;
        2'd1: stp_us = `OPDVR_STP1_US;
        2'd2: stp_us = `OPDVR_STP2_US;
        default: stp_us = `OPDVR_STP3_US;
      endcase
    end
  endfunction

  // microsecond base from the system clock
  assign tick     = (pre_ff == TICK_CYC - 16'd1);
  assign dly_done = (us_ff >= dly_us(dly_code));
  assign stp_done = (us_ff >= stp_us(stp_code));
  assign delaying = (state_ff == ST_DLY);
  assign powered  = (state_ff == ST_ON);

  // dropping the request aborts at once, so a restart always waits fully
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff     <= ST_IDLE;
      pre_ff       <= 16'h0000;
      us_ff        <= 22'h000000;
      stp_ff       <= 4'h0;
      ramp_step_ff <= 1'b0;
    end else begin
      ramp_step_ff <= 1'b0;
      pre_ff       <= (tick || state_ff == ST_IDLE) ? 16'h0000
                                                    : pre_ff + 16'h0001;
      if (tick) begin
        us_ff <= us_ff + 22'h000001;
      end
      if (!pwr_req) begin
        state_ff <= ST_IDLE;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_DLY;
            us_ff    <= 22'h000000;
            stp_ff   <= 4'h0;
          end
          ST_DLY: begin
            if (dly_done) begin
              state_ff <= ST_RAMP;
              us_ff    <= 22'h000000;
            end
          end
          ST_RAMP: begin
            if (stp_done) begin
              ramp_step_ff <= 1'b1;
              us_ff        <= 22'h000000;
              stp_ff       <= stp_ff + 4'h1;
              if (stp_ff == `OPDVR_RAMP_STEPS - 4'h1) begin
                state_ff <= ST_ON;
              end
            end
          end
          ST_ON: state_ff <= ST_ON;
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ===== src/opdvr_top.v
`timescale 1ns/10ps
`include "opdvr_consts.vh"

// pop reduction and dac digital volume register bank
module opdvr_top #(
  parameter [15:0] TICK_CYC = `OPDVR_TICK_CYC
) (
  input  wire        clk_sys,
  input  wire        nrst,
  // register port from the control bus decoder
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_ff,
  // settings kept elsewhere in the register space
  input  wire [1:0]  vol_link,
  input  wire [1:0]  soft_step_mode,
  input  wire        sample_rate_tick,
  // output driver power sequencing
  input  wire        drv_pwr_req,
  output wire        drv_delaying,
  output wire        drv_ramp_step,
  output wire        drv_powered,
  output wire        vcm_from_bandgap,
  // dac digital volume
  output wire        dac_l_mute,
  output wire        dac_r_mute,
  output wire [6:0]  dac_l_atten,
  output wire [6:0]  dac_r_atten,
  output wire        dac_vol_busy,
  // seven analog volume copies of one output stage input
  input  wire [48:0] ana_vol_codes,
  output reg  [69:0] ana_gain_tdb_ff,
  output reg  [6:0]  ana_mute_ff
);

  // ***************************************
  // registers and nets
  // ***************************************
  reg  [7:0] pop_ff;
  reg  [7:0] lvol_ff;
  reg  [7:0] rvol_ff;
  reg  [6:0] lcur_ff;
  reg  [6:0] rcur_ff;
  reg        half_ff;
  reg  [7:0] nxt_rdata;
  reg  [6:0] l_tgt;
  reg  [6:0] r_tgt;
  reg        step_now;
  wire       wr_pop;
  wire       wr_lvol;
  wire       wr_rvol;
  wire [69:0] lut_gain;
  wire [6:0]  lut_mute;
  wire        sel_pop;
  wire        sel_lvol;
  wire        sel_rvol;
  wire [3:0]  dly_field;
  wire [1:0]  stp_field;
  wire [6:0]  latt_field;
  wire [6:0]  ratt_field;
  wire        l_busy;
  wire        r_busy;

  // ***************************************
  // helpers
  // ***************************************

  // move one code towards the target, never overshooting
  function [6:0] step_toward;
    input [6:0] cur;
    input [6:0] tgt;
    begin
      if (cur < tgt) begin
        step_toward = cur + 7'd1;
      end else if (cur > tgt) begin
        step_toward = cur - 7'd1;
      end else begin
        step_toward = cur;
      end
    end
  endfunction

  // address match shared by the write strobes and the read path
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ***************************************
  // register writes
  // ***************************************

  // one decode per register, shared by writes and reads
  assign sel_pop  = hit(reg_addr, `OPDVR_OFS_POP);
  assign sel_lvol = hit(reg_addr, `OPDVR_OFS_LVOL);
  assign sel_rvol = hit(reg_addr, `OPDVR_OFS_RVOL);

  // write strobes per register
  assign wr_pop  = reg_wr && sel_pop;
  assign wr_lvol = reg_wr && sel_lvol;
  assign wr_rvol = reg_wr && sel_rvol;

  // bit 0 of the pop register is stored as written; software keeps it 0
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pop_ff <= `OPDVR_RST_POP;
    end else if (wr_pop) begin
      pop_ff <= reg_wdata;
    end
  end

  // left channel starts muted at 0 dB attenuation
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lvol_ff <= `OPDVR_RST_VOL;
    end else if (wr_lvol) begin
      lvol_ff <= reg_wdata;
    end
  end

  // right channel likewise, on its own strobe
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rvol_ff <= `OPDVR_RST_VOL;
    end else if (wr_rvol) begin
      rvol_ff <= reg_wdata;
    end
  end

  // ***************************************
  // register fields
  // ***************************************

  // named slices keep the bit positions in one place
  assign dly_field  = pop_ff[`OPDVR_POP_DLY_HI:`OPDVR_POP_DLY_LO];
  assign stp_field  = pop_ff[`OPDVR_POP_STP_HI:`OPDVR_POP_STP_LO];
  assign latt_field = lvol_ff[`OPDVR_VOL_ATT_HI:0];
  assign ratt_field = rvol_ff[`OPDVR_VOL_ATT_HI:0];

  // ***************************************
  // register reads
  // ***************************************

  // unmapped addresses read as zero
  always @* begin
    nxt_rdata = 8'h00;
    if (sel_pop) begin
      nxt_rdata = pop_ff;
    end else if (sel_lvol) begin
      nxt_rdata = lvol_ff;
    end else if (sel_rvol) begin
      nxt_rdata = rvol_ff;
    end
  end

  // read data held until the next read, one cycle after the strobe
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ***************************************
  // pop reduction
  // ***************************************

  // common-mode source is a plain level for the analog side
  assign vcm_from_bandgap = pop_ff[`OPDVR_POP_VCM_BIT];

  // the field is read live, so a rewrite during the wait retimes it
  opdvr_pwr_seq #(
    .TICK_CYC (TICK_CYC)
  ) u_pwr_seq (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .pwr_req      (drv_pwr_req),
    .dly_code     (dly_field),
    .stp_code     (stp_field),
    .delaying     (drv_delaying),
    .ramp_step_ff (drv_ramp_step),
    .powered      (drv_powered)
  );

  // ***************************************
  // dac volume linking
  // ***************************************

  // only the attenuation follows; each mute bit stays its own
  always @* begin
    case (vol_link)
      `OPDVR_LINK_L_FOLLOW: begin
        l_tgt = ratt_field;
        r_tgt = ratt_field;
      end
      `OPDVR_LINK_R_FOLLOW: begin
        l_tgt = latt_field;
        r_tgt = latt_field;
      end
      default: begin
        l_tgt = latt_field;
        r_tgt = ratt_field;
      end
    endcase
  end

  // ***************************************
  // soft stepping
  // ***************************************

  // reserved mode 11 is handled like disabled, jumping at once
  always @* begin
    case (soft_step_mode)
      `OPDVR_SS_EVERY:  step_now = sample_rate_tick;
      `OPDVR_SS_EVERY2: step_now = sample_rate_tick && half_ff;
      default:          step_now = 1'b0;
    endcase
  end

  // divides the sample strobe by two for the slow mode
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      half_ff <= 1'b0;
    end else if (sample_rate_tick) begin
      half_ff <= ~half_ff;
    end
  end

  // left applied code walks half a decibel per permitted step
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lcur_ff <= 7'h00;
    end else if (soft_step_mode[1]) begin
      lcur_ff <= l_tgt;
    end else if (step_now) begin
      lcur_ff <= step_toward(lcur_ff, l_tgt);
    end
  end

  // right applied code, same pace so a linked pair stays together
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rcur_ff <= 7'h00;
    end else if (soft_step_mode[1]) begin
      rcur_ff <= r_tgt;
    end else if (step_now) begin
      rcur_ff <= step_toward(rcur_ff, r_tgt);
    end
  end

  // busy until each applied code has reached its target
  assign l_busy       = (lcur_ff != l_tgt);
  assign r_busy       = (rcur_ff != r_tgt);
  assign dac_vol_busy = l_busy || r_busy;

  // applied codes go out straight from flip-flops
  assign dac_l_atten  = lcur_ff;
  assign dac_r_atten  = rcur_ff;

  // mute bits act at once, they never wait for a step
  assign dac_l_mute   = lvol_ff[`OPDVR_VOL_MUTE_BIT];
  assign dac_r_mute   = rvol_ff[`OPDVR_VOL_MUTE_BIT];

  // ***************************************
  // analog output stage volume copies
  // ***************************************

  // one decoder per copy keeps every driver mix independent
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_copy
      opdvr_vol_lut u_lut (
        .code      (ana_vol_codes[gi*7 +: 7]),
        .atten_tdb (lut_gain[gi*10 +: 10]),
        .muted     (lut_mute[gi])
      );
    end
  endgenerate

  // registered so the gains reach the analog side glitch free
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ana_gain_tdb_ff <= {70{1'b0}};
    end else begin
      ana_gain_tdb_ff <= lut_gain;
    end
  end

  // mutes move in the same cycle as the gains they override
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ana_mute_ff <= 7'h00;
    end else begin
      ana_mute_ff <= lut_mute;
    end
  end

endmodule

// ===== src/opdvr_vol_lut.v
`timescale 1ns/10ps
`include "opdvr_consts.vh"

// analog volume code to attenuation in tenths of a decibel
module opdvr_vol_lut (
  input  wire [6:0] code,
  output reg  [9:0] atten_tdb,
  output wire       muted
);

  wire [9:0] lin_tdb;

  // the low codes sit on an exact half-decibel grid
  assign lin_tdb = {3'b000, code} * 10'd5;
  assign muted   = (code >= `OPDVR_MUTE_FIRST);

  // table only for the irregular tail, saving most of the rows
  always @* begin
    if (code <= 7'd36) begin
      atten_tdb = lin_tdb;
    end else if (code <= 7'd70) begin
      atten_tdb = lin_tdb + 10'd1;
    end else if (code >= 7'd75 && code <= 7'd86) begin
      atten_tdb = lin_tdb + 10'd2;
    end else begin
      case (code)
        7'd71: atten_tdb = 10'd357;  7'd72: atten_tdb = 10'd361;
        7'd73: atten_tdb = 10'd367;  7'd74: atten_tdb = 10'd371;
        7'd87: atten_tdb = 10'd438;  7'd88: atten_tdb = 10'd443;
        7'd89: atten_tdb = 10'd448;  7'd90: atten_tdb = 10'd452;
        7'd91: atten_tdb = 10'd458;  7'd92: atten_tdb = 10'd462;
        7'd93: atten_tdb = 10'd467;  7'd94: atten_tdb = 10'd474;
        7'd95: atten_tdb = 10'd479;  7'd96: atten_tdb = 10'd482;
        7'd97: atten_tdb = 10'd487;  7'd98: atten_tdb = 10'd493;
        7'd99: atten_tdb = 10'd500;  7'd100: atten_tdb = 10'd503;
        7'd101: atten_tdb = 10'd510; 7'd102: atten_tdb = 10'd514;
        7'd103: atten_tdb = 10'd518; 7'd104: atten_tdb = 10'd522;
        7'd105: atten_tdb = 10'd527; 7'd106: atten_tdb = 10'd537;
        7'd107: atten_tdb = 10'd542; 7'd108: atten_tdb = 10'd553;
        7'd109: atten_tdb = 10'd567; 7'd110: atten_tdb = 10'd583;
        7'd111: atten_tdb = 10'd602; 7'd112: atten_tdb = 10'd627;
        7'd113: atten_tdb = 10'd643; 7'd114: atten_tdb = 10'd662;
        7'd115: atten_tdb = 10'd687; 7'd116: atten_tdb = 10'd722;
        7'd117: atten_tdb = 10'd783;
        default: atten_tdb = 10'd783; // muted codes report full depth
      endcase
    end
  end

endmodule
